// File: rtl/ladder_pkg.sv
// Purpose: shared constants and types for the ladder operand/execution control
// Assumes: one clock domain, synchronous active-high reset
// Notes:   run-state codes follow a gray path stop->prime->first->active
`default_nettype none
package ladder_pkg;
    // data path widths
    localparam int          WORD_W      = 32;
    localparam int          HALF_W      = 16;
    localparam int          NIB_W       = 4;
    localparam int          CODE_W      = 16;
    // nibble-count limits per instruction width
    localparam logic [3:0]  NIB_MAX_16  = 4'h4;
    localparam logic [3:0]  NIB_MAX_32  = 4'h8;
    localparam logic [3:0]  NIB_MIN     = 4'h1;
    // values after reset
    localparam logic [15:0] CODE_RESET  = 16'h0000;
    // code stored for an illegal nibble count (arbitrary value)
    localparam logic [15:0] CODE_WIDTH  = 16'h00C1;

    // run/stop sequencing
    typedef enum logic [2:0] {
        RUN_STOP   = 3'h0,
        RUN_PRIME  = 3'h1,
        RUN_FIRST  = 3'h3,
        RUN_ACTIVE = 3'h2,
        RUN_HALT   = 3'h6
    } run_e;

    // execution condition of one instruction
    typedef enum logic [2:0] {
        EXEC_ALWAYS = 3'h0,
        EXEC_ON     = 3'h1,
        EXEC_OFF    = 3'h2,
        EXEC_RISE   = 3'h3,
        EXEC_FALL   = 3'h4
    } exec_e;
endpackage
`default_nettype wire

// File: rtl/ladder_step_if.sv
// Purpose: carries one instruction step between control and its helper units
// Assumes: purely combinational paths inside one clock domain
// Notes:   opnd and cond face the helpers, ctl faces the control
`default_nettype none
interface ladder_step_if;
    logic [31:0]           srcRaw;     // raw source bits
    logic [31:0]           dstOld;     // destination contents before the write
    logic [31:0]           result;     // value computed by the engine
    logic [3:0]            srcNib;     // source nibble count
    logic [3:0]            dstNib;     // destination nibble count
    logic                  srcDigit;   // source is digit-specified
    logic                  dstDigit;   // destination is digit-specified
    logic                  dbl;        // 32-bit variant
    logic                  seqClass;   // single-bit sequence instruction
    logic [31:0]           srcVal;     // extended source value
    logic [31:0]           dstVal;     // extended destination operand
    logic [31:0]           dstMask;    // points that may be written
    logic [31:0]           dstMerged;  // destination after the write
    logic                  widthBad;   // nibble count out of range
    ladder_pkg::exec_e     kind;       // effective execution condition
    logic                  prior;      // prior condition this scan
    logic                  prev;       // prior condition last scan
    logic                  fire;       // instruction executes
    logic                  offAction;  // always-type off processing

    modport opnd (input srcRaw, dstOld, result, srcNib, dstNib, srcDigit, dstDigit, dbl, seqClass,
                  output srcVal, dstVal, dstMask, dstMerged, widthBad);
    modport cond (input kind, prior, prev, output fire, offAction);
    modport ctl  (output srcRaw, dstOld, result, srcNib, dstNib, srcDigit, dstDigit, dbl, seqClass,
                  kind, prior, prev,
                  input srcVal, dstVal, dstMask, dstMerged, widthBad, fire, offAction);
endinterface
`default_nettype wire

// File: rtl/operand_unit.sv
// Purpose: operand width, extension and destination masking
// Assumes: nibble counts arrive with the instruction
// Notes:   purely combinational; the control registers the results
`default_nettype none
module operand_unit (
    // step carrier
    ladder_step_if.opnd port
);
    // points covered by a nibble count
    function automatic logic [31:0] nibMask(input logic [3:0] nib);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nib) begin
                m[i*4 +: 4] = 4'hF;
            end
        end
        return m;
    endfunction

    // short groups zero-extend, a full group is signed
    function automatic logic [31:0] extend(input logic [31:0] raw, input logic [3:0] nib, input logic dbl);
        logic [31:0] v;
        v = raw & nibMask(nib);
        if (!dbl && nib == ladder_pkg::NIB_MAX_16) begin
            v = {{16{v[15]}}, v[15:0]};
        end
        return v;
    endfunction

    // word operands: 16-bit signed, 32-bit as is
    function automatic logic [31:0] wordVal(input logic [31:0] raw, input logic dbl);
        return dbl ? raw : {{16{raw[15]}}, raw[15:0]};
    endfunction

    // nibble count outside 1..4 or 1..8
    function automatic logic badNib(input logic [3:0] nib, input logic dbl);
        return nib < ladder_pkg::NIB_MIN || nib > (dbl ? ladder_pkg::NIB_MAX_32 : ladder_pkg::NIB_MAX_16);
    endfunction

    // operand shaping
    always_comb begin
        if (port.seqClass) begin
            // one point only, groups are never taken
            port.srcVal   = {31'h00000000, port.srcRaw[0]};
            port.dstVal   = {31'h00000000, port.dstOld[0]};
            port.dstMask  = 32'h00000001;
            port.widthBad = 1'b0;
        end else begin
            port.srcVal   = port.srcDigit ? extend(port.srcRaw, port.srcNib, port.dbl)
                                          : wordVal(port.srcRaw, port.dbl);
            // destination is itself an operand
            port.dstVal   = port.dstDigit ? extend(port.dstOld, port.dstNib, port.dbl)
                                          : wordVal(port.dstOld, port.dbl);
            port.dstMask  = port.dstDigit ? nibMask(port.dstNib)
                                          : (port.dbl ? 32'hFFFFFFFF : 32'h0000FFFF);
            port.widthBad = (port.srcDigit && badNib(port.srcNib, port.dbl))
                         || (port.dstDigit && badNib(port.dstNib, port.dbl));
        end
        // points beyond the count keep their old value
        port.dstMerged = (port.dstOld & ~port.dstMask) | (port.result & port.dstMask);
    end
endmodule // operand_unit
`default_nettype wire

// File: rtl/cond_decoder.sv
// Purpose: execution-condition decode for one instruction step
// Assumes: prev holds the prior condition from the previous scan
// Notes:   combinational; the edge record lives in the control
`default_nettype none
module cond_decoder (
    // step carrier
    ladder_step_if.cond port
);
    // decode by condition kind
    always_comb begin
        port.offAction = 1'b0;
        unique case (port.kind)
            ladder_pkg::EXEC_ALWAYS: begin
                port.fire      = 1'b1;
                port.offAction = !port.prior;
            end
            ladder_pkg::EXEC_ON: begin
                port.fire = port.prior;
            end
            ladder_pkg::EXEC_OFF: begin
                port.fire = !port.prior;
            end
            ladder_pkg::EXEC_RISE: begin
                port.fire = port.prior && !port.prev;
            end
            ladder_pkg::EXEC_FALL: begin
                port.fire = !port.prior && port.prev;
            end
            // unused codes never execute
            default: begin
                port.fire = 1'b0;
            end
        endcase
    end
endmodule // cond_decoder
`default_nettype wire

// File: rtl/ladder_operand_exec_control.sv
// Purpose: run/stop output handling, operand shaping, error latch and
//          execution-condition control of the ladder engine
// Assumes: engine presents one instruction per cycle while scanEnable is high
// Notes:   every output comes from a flop, so step results lag one cycle
`default_nettype none
module ladder_operand_exec_control #(
    parameter int Y_W    = 16,  // output relay points
    parameter int SLOTS  = 64,  // edge-qualified instruction slots
    parameter int ADDR_W = 16   // word device address width
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // run control and options
    input  wire logic              runRequest,
    input  wire logic              restoreOutputs,
    input  wire logic              haltOnError,
    // instruction step
    input  wire logic              instValid,
    input  wire logic              instSeqClass,
    input  wire logic              instDouble,
    input  wire logic              instPulse,
    input  wire logic [2:0]        instKind,
    input  wire logic [$clog2(SLOTS)-1:0] instSlot,
    input  wire logic              priorCond,
    // operands
    input  wire logic [31:0]       srcRaw,
    input  wire logic [3:0]        srcNib,
    input  wire logic              srcDigit,
    input  wire logic [31:0]       dstOld,
    input  wire logic [3:0]        dstNib,
    input  wire logic              dstDigit,
    input  wire logic [31:0]       result,
    input  wire logic [ADDR_W-1:0] dstWordAddr,
    // error report and scan end
    input  wire logic              opError,
    input  wire logic [15:0]       opErrorCode,
    input  wire logic              errClear,
    input  wire logic              scanEnd,
    input  wire logic [Y_W-1:0]    yImage,
    // run status and outputs
    output logic                   scanEnable,
    output logic                   halted,
    output logic [Y_W-1:0]         yOut,
    output logic                   errFlag,
    output logic [15:0]            errCode,
    // step results
    output logic                   stepValid,
    output logic                   stepFire,
    output logic                   stepOffAction,
    output logic                   stepCommit,
    output logic [31:0]            srcValue,
    output logic [31:0]            dstValue,
    output logic [31:0]            dstMask,
    output logic [31:0]            dstData,
    // word store
    output logic [15:0]            wordLo,
    output logic [15:0]            wordHi,
    output logic                   wordHiEnable,
    output logic [ADDR_W-1:0]      wordAddr,
    output logic [ADDR_W-1:0]      wordAddrNext
);
    localparam int SLOT_W = $clog2(SLOTS);

    // refuse sizes the logic cannot serve
    if (Y_W < 1 || SLOTS < 2 || ADDR_W < 2) begin : g_bad_param
        $error("ladder_operand_exec_control: Y_W>=1, SLOTS>=2, ADDR_W>=2 required");
    end

    // whole state of the block
    typedef struct packed {
        ladder_pkg::run_e  run;
        logic              runMeta;    // first synchroniser flop
        logic              runSync;    // synchronised run request
        logic [Y_W-1:0]    yOut;
        logic [Y_W-1:0]    saved;      // image kept over stop
        logic [SLOTS-1:0]  edgeRec;    // last prior condition per slot
        logic              errFlag;
        logic [15:0]       errCode;
        logic              scanEnable;
        logic              stepValid;
        logic              stepFire;
        logic              stepOff;
        logic              stepCommit;
        logic [31:0]       srcValue;
        logic [31:0]       dstValue;
        logic [31:0]       dstMask;
        logic [31:0]       dstData;
        logic              wordHiEn;
        logic [ADDR_W-1:0] wordAddr;
        logic [ADDR_W-1:0] wordAddrNext;
        logic              halted;     // error stop, held in a flop for the port
    } state_s;

    state_s s;       // registered state
    state_s next_s;  // value for the next edge
    logic   stepErr; // executing step faulted
    logic   running; // scan is allowed this cycle

    ladder_step_if stp ();

    // helper units
    operand_unit uOpnd (
        .port (stp)
    );
    cond_decoder uCond (
        .port (stp)
    );

    // feed the helpers
    assign stp.srcRaw   = srcRaw;
    assign stp.dstOld   = dstOld;
    assign stp.result   = result;
    assign stp.srcNib   = srcNib;
    assign stp.dstNib   = dstNib;
    assign stp.srcDigit = srcDigit;
    assign stp.dstDigit = dstDigit;
    assign stp.dbl      = instDouble;
    assign stp.seqClass = instSeqClass;
    assign stp.kind     = instPulse ? ladder_pkg::EXEC_RISE : ladder_pkg::exec_e'(instKind);
    assign stp.prior    = priorCond;
    assign stp.prev     = s.edgeRec[instSlot];

    // a width fault counts as an operation error; area overrun does not
    assign running = s.scanEnable && (s.run == ladder_pkg::RUN_ACTIVE || s.run == ladder_pkg::RUN_FIRST);
    assign stepErr = running && instValid && stp.fire && (opError || stp.widthBad);

    // next-state logic
    always_comb begin
        next_s            = s;
        next_s.runMeta    = runRequest;
        next_s.runSync    = s.runMeta;
        next_s.stepValid  = 1'b0;
        next_s.stepFire   = 1'b0;
        next_s.stepOff    = 1'b0;
        next_s.stepCommit = 1'b0;
        next_s.wordHiEn   = 1'b0;

        // run/stop sequencing
        unique case (s.run)
            ladder_pkg::RUN_STOP: begin
                next_s.yOut       = '0;
                next_s.scanEnable = 1'b0;
                if (s.runSync) begin
                    // restore shows the old image before any scan
                    next_s.yOut = restoreOutputs ? s.saved : '0;
                    next_s.run  = ladder_pkg::RUN_PRIME;
                end
            end
            ladder_pkg::RUN_PRIME: begin
                if (!s.runSync) begin
                    next_s.yOut = '0;
                    next_s.run  = ladder_pkg::RUN_STOP;
                end else begin
                    next_s.scanEnable = 1'b1;
                    next_s.run = restoreOutputs ? ladder_pkg::RUN_ACTIVE : ladder_pkg::RUN_FIRST;
                end
            end
            ladder_pkg::RUN_FIRST: begin
                // outputs stay cleared until the first scan ends
                if (!s.runSync) begin
                    next_s.scanEnable = 1'b0;
                    next_s.run        = ladder_pkg::RUN_STOP;
                end else if (scanEnd) begin
                    next_s.yOut = yImage;
                    next_s.run  = ladder_pkg::RUN_ACTIVE;
                end
            end
            ladder_pkg::RUN_ACTIVE: begin
                if (!s.runSync) begin
                    next_s.saved      = s.yOut;
                    next_s.yOut       = '0;
                    next_s.scanEnable = 1'b0;
                    next_s.run        = ladder_pkg::RUN_STOP;
                end else if (scanEnd) begin
                    next_s.yOut = yImage;
                end
            end
            ladder_pkg::RUN_HALT: begin
                // error stop: only a stop request leaves it
                next_s.yOut       = '0;
                next_s.scanEnable = 1'b0;
                if (!s.runSync) begin
                    next_s.run = ladder_pkg::RUN_STOP;
                end
            end
            default: begin
                next_s.yOut       = '0;
                next_s.scanEnable = 1'b0;
                next_s.run        = ladder_pkg::RUN_STOP;
            end
        endcase

        // one instruction step
        if (running && instValid) begin
            next_s.edgeRec[instSlot] = priorCond;
            next_s.stepValid = 1'b1;
            next_s.stepFire  = stp.fire;
            next_s.stepOff   = stp.offAction;
            // a faulting step is skipped; unless haltOnError stops the scan, the next one proceeds
            next_s.stepCommit = stp.fire && !stepErr;
            next_s.srcValue   = stp.srcVal;
            next_s.dstValue   = stp.dstVal;
            next_s.dstMask    = stp.dstMask;
            next_s.dstData    = stp.dstMerged;
            // upper word goes to the following device, wrap is silent
            next_s.wordHiEn     = instDouble && stp.fire && !stepErr;
            next_s.wordAddr     = dstWordAddr;
            next_s.wordAddrNext = dstWordAddr + ADDR_W'(1);
        end

        // error flag: program clear, but a new error wins
        if (errClear) begin
            next_s.errFlag = 1'b0;
            next_s.errCode = ladder_pkg::CODE_RESET;
        end
        if (stepErr) begin
            next_s.errFlag = 1'b1;
            if (!s.errFlag || errClear) begin
                next_s.errCode = stp.widthBad ? ladder_pkg::CODE_WIDTH : opErrorCode;
            end
            // halt option stops at once with outputs off
            if (haltOnError && s.runSync) begin
                if (s.run == ladder_pkg::RUN_ACTIVE) begin
                    next_s.saved = s.yOut;
                end
                next_s.yOut       = '0;
                next_s.scanEnable = 1'b0;
                next_s.run        = ladder_pkg::RUN_HALT;
            end
        end
        // port copy of the error stop, so halted comes from a flop
        next_s.halted = (next_s.run == ladder_pkg::RUN_HALT);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign scanEnable    = s.scanEnable;
    assign halted        = s.halted;
    assign yOut          = s.yOut;
    assign errFlag       = s.errFlag;
    assign errCode       = s.errCode;
    assign stepValid     = s.stepValid;
    assign stepFire      = s.stepFire;
    assign stepOffAction = s.stepOff;
    assign stepCommit    = s.stepCommit;
    assign srcValue      = s.srcValue;
    assign dstValue      = s.dstValue;
    assign dstMask       = s.dstMask;
    assign dstData       = s.dstData;
    assign wordLo        = s.dstData[15:0];
    assign wordHi        = s.dstData[31:16];
    assign wordHiEnable  = s.wordHiEn;
    assign wordAddr      = s.wordAddr;
    assign wordAddrNext  = s.wordAddrNext;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence leaveRun;
        s.run == ladder_pkg::RUN_ACTIVE && !s.runSync;
    endsequence
    sequence primeRestore;
        s.run == ladder_pkg::RUN_STOP && s.runSync && restoreOutputs;
    endsequence
    sequence stepIn;
        running && instValid;
    endsequence

    a_stop_off: assert property (s.run == ladder_pkg::RUN_STOP |-> s.yOut == '0 && !s.scanEnable)
        else $error("outputs or scan active while stopped");
    a_save_image: assert property (leaveRun |=> s.saved == $past(s.yOut) && s.run == ladder_pkg::RUN_STOP)
        else $error("output image not saved on stop");
    a_restore_first: assert property (primeRestore |=> s.yOut == $past(s.saved) && !s.scanEnable)
        else $error("saved image not shown before scan");
    a_clear_scan: assert property (s.run == ladder_pkg::RUN_FIRST |-> s.yOut == '0)
        else $error("outputs driven during cleared first scan");
    a_err_sticky: assert property (s.errFlag && !errClear |=> s.errFlag)
        else $error("error flag dropped without clear");
    a_code_hold: assert property (s.errFlag && !errClear |=> $stable(s.errCode))
        else $error("error code changed while flag set");
    a_err_sets: assert property (stepErr |=> s.errFlag && !s.stepCommit && s.stepValid)
        else $error("error not latched or faulting step committed");
    a_halt_mode: assert property (stepErr && haltOnError && s.runSync |=> halted && s.yOut == '0)
        else $error("halt option did not stop the scan");
    a_while_on: assert property (
        stepIn and (stp.kind == ladder_pkg::EXEC_ON) |=> s.stepFire == $past(priorCond))
        else $error("while-on step mismatched condition");
    a_while_off: assert property (
        stepIn and (stp.kind == ladder_pkg::EXEC_OFF) |=> s.stepFire != $past(priorCond))
        else $error("while-off step mismatched condition");
    a_rise_once: assert property (
        stepIn and (stp.kind == ladder_pkg::EXEC_RISE) and stp.prev |=> !s.stepFire)
        else $error("rising step fired again");
    a_fall_once: assert property (
        stepIn and (stp.kind == ladder_pkg::EXEC_FALL) and !stp.prev |=> !s.stepFire)
        else $error("falling step fired again");
    a_dest_keep: assert property (stepIn |=> ((s.dstData ^ $past(dstOld)) & ~s.dstMask) == 32'h00000000)
        else $error("points outside the group changed");
endmodule // ladder_operand_exec_control
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench for ladder_operand_exec_control
// Assumes: inputs change on the falling edge of sys_clk
// Notes:   each scenario is one task, all comparisons go through chk
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus, all quiet at time zero except sys_rst, which starts high
    logic sys_clk = '0, sys_rst = '1, runRequest = '0, restoreOutputs = '0, haltOnError = '0;
    logic instValid = '0, instSeqClass = '0, instDouble = '0, instPulse = '0, priorCond = '0;
    logic srcDigit = '0, dstDigit = '0, opError = '0, errClear = '0, scanEnd = '0;
    logic [2:0] instKind = '0;
    logic [5:0] instSlot = '0;
    logic [3:0] srcNib = '0, dstNib = '0;
    logic [31:0] srcRaw = '0, dstOld = '0, result = '0, srcValue, dstValue, dstMask, dstData;
    logic [15:0] dstWordAddr = '0, opErrorCode = '0, yImage = '0, yOut, errCode, wordLo, wordHi;
    logic [15:0] wordAddr, wordAddrNext;
    logic scanEnable, halted, errFlag, stepValid, stepFire, stepOffAction, stepCommit, wordHiEnable;
    int mismatches = 0, total_checks = 0;
    // 4 ns clock
    always #2 sys_clk = ~sys_clk;
    ladder_operand_exec_control uut (.sys_clk, .sys_rst, .runRequest, .restoreOutputs, .haltOnError,
        .instValid, .instSeqClass, .instDouble, .instPulse, .instKind, .instSlot, .priorCond, .srcRaw,
        .srcNib, .srcDigit, .dstOld, .dstNib, .dstDigit, .result, .dstWordAddr, .opError, .opErrorCode,
        .errClear, .scanEnd, .yImage, .scanEnable, .halted, .yOut, .errFlag, .errCode, .stepValid,
        .stepFire, .stepOffAction, .stepCommit, .srcValue, .dstValue, .dstMask, .dstData, .wordLo,
        .wordHi, .wordHiEnable, .wordAddr, .wordAddrNext);
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("mismatches %0d, checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one step; returns in the cycle its registered results show
    task automatic go();
        @(negedge sys_clk) instValid = 1'b1;
        @(negedge sys_clk) instValid = 1'b0;
    endtask
    // bounded wait: the synchroniser adds two cycles, stop and prime one each
    task automatic start(logic rs);
        restoreOutputs = rs;
        runRequest = 1'b1;
        for (int i = 0; i < 10 && scanEnable !== 1'b1; i++) @(negedge sys_clk);
        chk("scanEnable", scanEnable, 32'h1);
    endtask
    task automatic t_clear();
        chk("yOut stop", yOut, 0);
        start(1'b0);
        chk("yOut first", yOut, 0);
        yImage = 16'hA5A5;
        @(negedge sys_clk) scanEnd = 1'b1;
        @(negedge sys_clk) scanEnd = 1'b0;
        chk("yOut scan", yOut, 16'hA5A5);
    endtask
    // prior pattern off,on,on,off per kind; last row is while-on with pulse suffix
    task automatic t_cond();
        logic [3:0] fires[6] = '{4'hF, 4'h6, 4'h9, 4'h2, 4'h8, 4'h2};
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 4; i++) begin
                instKind = (k == 5) ? 3'h1 : 3'(k);
                instPulse = (k == 5);
                instSlot = 6'(k + 1);
                priorCond = (i == 1 || i == 2);
                go();
                chk("fire", stepFire, fires[k][i]);
                if (k == 0) chk("offAction", stepOffAction, !priorCond);
            end
        end
        instPulse = 1'b0;
    endtask
    // nibble widths at the sign boundaries, destination at the last word address
    task automatic t_opnd();
        logic [31:0] raw[4] = '{32'h00008001, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h80000000};
        logic [31:0] ext[4] = '{32'hFFFF8001, 32'h00000FFF, 32'h0FFFFFFF, 32'h80000000};
        logic [3:0] nib[4] = '{4'h4, 4'h3, 4'h7, 4'h8};
        logic [31:0] m;
        srcDigit = 1'b1;
        dstDigit = 1'b1;
        instKind = 3'h0;
        priorCond = 1'b1;
        dstOld = 32'h5A5A5A5A;
        result = '1;
        dstWordAddr = 16'hFFFF;
        for (int i = 0; i < 4; i++) begin
            srcRaw = raw[i];
            srcNib = nib[i];
            dstNib = nib[i];
            instDouble = (i > 1);
            go();
            m = (nib[i] == 4'h8) ? '1 : (32'h1 << (4 * nib[i])) - 32'h1;
            chk("srcValue", srcValue, ext[i]);
            chk("dstMask", dstMask, m);
            chk("dstData", dstData, dstOld | m);
            chk("wordHiEnable", wordHiEnable, instDouble);
            chk("dstValue", dstValue, dstOld & m);
            chk("words", {wordHi, wordLo}, dstOld | m);
        end
        chk("wordAddr", wordAddr, 16'hFFFF);
        chk("wordAddrNext", wordAddrNext, 16'h0000);
        instSeqClass = 1'b1;
        srcNib = 4'h0;
        go();
        chk("seq mask", dstMask, 32'h1);
        chk("errFlag", errFlag, 0);
        instSeqClass = 1'b0;
        // plain word source, 16-bit reads signed
        instDouble = 1'b0;
        srcDigit = 1'b0;
        srcRaw = 32'h00008000;
        dstNib = 4'h4;
        go();
        chk("word src", srcValue, 32'hFFFF8000);
        srcDigit = 1'b1;
    endtask
    task automatic t_err();
        instDouble = 1'b0;
        srcNib = 4'h5;
        dstNib = 4'h1;
        go();
        chk("errCode", errCode, ladder_pkg::CODE_WIDTH);
        chk("commit", stepCommit, 0);
        srcNib = 4'h1;
        opError = 1'b1;
        opErrorCode = 16'h1234;
        go();
        opError = 1'b0;
        chk("errCode", errCode, ladder_pkg::CODE_WIDTH);
        go();
        chk("errFlag", errFlag, 1);
        chk("halted", halted, 0);
        chk("commit", stepCommit, 1);
        @(negedge sys_clk) errClear = 1'b1;
        @(negedge sys_clk) errClear = 1'b0;
        chk("errFlag", errFlag, 0);
        chk("errCode clr", errCode, 16'h0000);
    endtask
    task automatic t_halt();
        haltOnError = 1'b1;
        opError = 1'b1;
        go();
        opError = 1'b0;
        chk("halted", halted, 1);
        chk("yOut", yOut, 0);
        go();
        chk("refused", stepValid, 0);
        runRequest = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("halted", halted, 0);
        start(1'b1);
        chk("yOut restore", yOut, 16'hA5A5);
    endtask
    // plain stop from run saves the latest image, restore shows it again
    task automatic t_stop();
        yImage = 16'h3C3C;
        @(negedge sys_clk) scanEnd = 1'b1;
        @(negedge sys_clk) scanEnd = 1'b0;
        chk("yOut run", yOut, 16'h3C3C);
        runRequest = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("yOut stopped", yOut, 16'h0000);
        chk("scan stopped", scanEnable, 32'h0);
        start(1'b1);
        chk("yOut saved", yOut, 16'h3C3C);
    endtask
    // watchdog, far beyond the roughly 120 cycles the scenarios need
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        results();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_clear();
        t_cond();
        t_opnd();
        t_err();
        t_halt();
        t_stop();
        results();
    end
endmodule // tb
`default_nettype wire
